// file: hdl/spd_eeprom_serial_access.sv
// Slave command engine of a two-page serial presence-detect memory.
// Assumes an external byte-wide array: reads answer the next cycle,
// writes are handed over with valid/ready; protection bits live outside.
`timescale 1ns/1ps
module spd_eeprom_serial_access
	import spd_pkg::*;
#(
	parameter int PROG_CYCLES = PROGRAM_CYCLE_CLKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic strap_addr_bit2,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit0,
	input wire logic high_voltage_detect,
	output logic [8:0] mem_rd_addr,
	input wire logic [7:0] mem_rd_data,
	output logic mem_wr_en,
	output logic [8:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	input wire logic mem_wr_ready,
	input wire logic [3:0] prot_nv_in,
	output logic [3:0] prot_nv_out,
	output logic prot_nv_wr,
	output logic busy
);
	// ********************************
	// Sampled pins
	// ********************************
	logic scl_rise, scl_fall, sda_level, start_evt, stop_evt, hv_level;
	logic [2:0] strap_level;

	spd_line_sampler u_sampler (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.strap_in({strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}),
		.hv_in(high_voltage_detect),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.sda_level(sda_level),
		.start_evt(start_evt),
		.stop_evt(stop_evt),
		.strap_level(strap_level),
		.hv_level(hv_level)
	);

	// ********************************
	// Write path FIFO
	// ********************************
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [WR_WORD_W-1:0] fifo_in_data, fifo_out_data;

	spd_fifo #(.WIDTH(WR_WORD_W), .DEPTH(WR_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ********************************
	// State
	// ********************************
	state_t state, next_state;
	cmd_t cmd, next_cmd;
	logic [7:0] shreg, next_shreg, addr, next_addr;
	logic [3:0] bitcnt, next_bitcnt, prot, next_prot, row, next_row;
	logic [1:0] blk, next_blk;
	logic page, next_page, pend, next_pend, acked, next_acked;
	logic oe_n, next_oe_n, loaded, next_loaded, nv_wr, next_nv_wr;
	logic [31:0] timer, next_timer;
	logic [4:0] drain, next_drain;
	logic [7:0] buf_data [ROW_BYTES];
	logic [ROW_BYTES-1:0] buf_valid, next_buf_valid;
	logic buf_we;
	logic wr_en, next_wr_en;
	logic [WR_WORD_W-1:0] wr_word, next_wr_word;
	logic sel_ack, sel_read;
	logic prog_busy, next_prog_busy;
	logic [1:0] sel_blk;
	logic [3:0] drain_idx;

	// ********************************
	// Select code decode
	// ********************************
	always_comb begin
		sel_ack = 1'b0;
		sel_read = shreg[0];
		sel_blk = 2'h0;
		unique case (shreg[3:1])
			SEL_BLOCK0: sel_blk = 2'h0;
			SEL_BLOCK1: sel_blk = 2'h1;
			SEL_BLOCK2: sel_blk = 2'h2;
			SEL_BLOCK3: sel_blk = 2'h3;
			default: sel_blk = 2'h0;
		endcase
		if (shreg[7:4] == TYPE_MEMORY) begin
			sel_ack = shreg[3:1] == strap_level;
		end else if (shreg[7:4] == TYPE_PROTECT) begin
			unique case ({shreg[3:1], shreg[0]})
				{SEL_CLEAR_ALL, 1'b0}: sel_ack = hv_level;
				{SEL_PAGE_LOW, 1'b0}, {SEL_PAGE_HIGH, 1'b0}: sel_ack = 1'b1;
				{SEL_PAGE_READ, 1'b1}: sel_ack = page == 1'b0;
				{SEL_BLOCK0, 1'b0}, {SEL_BLOCK1, 1'b0},
				{SEL_BLOCK2, 1'b0}, {SEL_BLOCK3, 1'b0}:
					sel_ack = hv_level & ~prot[sel_blk];
				{SEL_BLOCK0, 1'b1}, {SEL_BLOCK1, 1'b1},
				{SEL_BLOCK2, 1'b1}, {SEL_BLOCK3, 1'b1}:
					sel_ack = ~prot[sel_blk];
				default: sel_ack = 1'b0;
			endcase
		end
	end

	// ********************************
	// Engine next state
	// ********************************
	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_shreg = shreg;
		next_addr = addr;
		next_bitcnt = bitcnt;
		next_prot = prot;
		next_row = row;
		next_blk = blk;
		next_page = page;
		next_pend = pend;
		next_acked = acked;
		next_oe_n = oe_n;
		next_loaded = 1'b1;
		next_nv_wr = 1'b0;
		next_timer = timer;
		next_drain = drain;
		next_buf_valid = buf_valid;
		buf_we = 1'b0;
		drain_idx = drain[3:0];
		fifo_in_valid = 1'b0;
		fifo_in_data = {page, row, drain_idx, buf_data[drain_idx]};
		if (!loaded) begin
			// Protection read back from the nonvolatile store after reset
			next_prot = prot_nv_in;
		end
		if (state == ST_BUSY) begin
			// Pins are not looked at here, so polling gets no ack
			next_oe_n = 1'b1;
			if (timer != PROG_CYCLES - 1) begin
				next_timer = timer + 32'h1;
			end
			if (cmd == CMD_MEMORY && drain != DRAIN_DONE) begin
				fifo_in_valid = buf_valid[drain_idx];
				if (!buf_valid[drain_idx] || fifo_in_ready) begin
					next_drain = drain + 5'h1;
				end
			end
			if (timer == PROG_CYCLES - 1 && (cmd != CMD_MEMORY ||
				(drain == DRAIN_DONE && !fifo_out_valid && !wr_en))) begin
				next_state = ST_IDLE;
				next_buf_valid = '0;
				if (cmd == CMD_SET_BLOCK) begin
					next_prot[blk] = 1'b1;
					next_nv_wr = 1'b1;
				end else if (cmd == CMD_CLEAR_ALL) begin
					next_prot = 4'h0;
					next_nv_wr = 1'b1;
				end
			end
		end else if (stop_evt) begin
			next_oe_n = 1'b1;
			next_state = ST_IDLE;
			// The clock rise ahead of the stop already counts as one bit
			if (state == ST_WDATA && bitcnt == 4'h1 && pend) begin
				next_state = ST_BUSY;
				next_timer = 32'h0;
				next_drain = 5'h0;
			end
		end else if (start_evt) begin
			next_oe_n = 1'b1;
			next_state = ST_SEL;
			next_bitcnt = 4'h0;
			next_pend = 1'b0;
			next_buf_valid = '0;
		end else begin
			unique case (state)
				ST_IDLE, ST_BUSY: next_oe_n = 1'b1;
				ST_SEL, ST_ADDR, ST_WDATA: begin
					if (scl_rise && bitcnt != BIT_COUNT_FULL) begin
						next_shreg = {shreg[6:0], sda_level};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BIT_COUNT_FULL) begin
						next_bitcnt = 4'h0;
						next_oe_n = 1'b0;
						if (state == ST_SEL) begin
							next_state = sel_ack ? ST_SEL_ACK : ST_IDLE;
							next_oe_n = ~sel_ack;
							next_blk = sel_blk;
							next_cmd = CMD_MEMORY;
							if (shreg[7:4] == TYPE_PROTECT && shreg[3:1] == SEL_CLEAR_ALL) begin
								next_cmd = CMD_CLEAR_ALL;
							end else if (shreg[7:4] == TYPE_PROTECT && !sel_read && shreg[3:1]
								inside {SEL_BLOCK0, SEL_BLOCK1, SEL_BLOCK2, SEL_BLOCK3}) begin
								next_cmd = CMD_SET_BLOCK;
							end
							if (shreg[7:4] == TYPE_PROTECT && shreg[3:2] == 2'h3
								&& !shreg[0]) begin
								next_page = shreg[1];
							end
						end else if (state == ST_ADDR) begin
							next_state = ST_ADDR_ACK;
							if (cmd == CMD_MEMORY) begin
								next_addr = shreg;
								next_row = shreg[7:4];
							end
						end else if (cmd == CMD_MEMORY && prot[{page, addr[7]}]) begin
							next_state = ST_IDLE;
							next_oe_n = 1'b1;
							next_pend = 1'b0;
						end else begin
							next_state = ST_WDATA_ACK;
							if (cmd == CMD_MEMORY) begin
								buf_we = 1'b1;
								next_buf_valid[addr[3:0]] = 1'b1;
								next_addr = {addr[7:4], addr[3:0] + 4'h1};
							end
						end
					end
				end
				ST_SEL_ACK, ST_ADDR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_oe_n = 1'b1;
						next_bitcnt = 4'h0;
						if (state == ST_SEL_ACK) begin
							// Protection commands other than set/clear end here
							if (shreg[7:4] == TYPE_MEMORY && shreg[0]) begin
								next_state = ST_RDATA;
								next_shreg = mem_rd_data;
								next_oe_n = mem_rd_data[7];
								next_bitcnt = 4'h1;
							end else if (shreg[7:4] == TYPE_MEMORY || cmd != CMD_MEMORY) begin
								next_state = ST_ADDR;
							end else begin
								next_state = ST_IDLE;
							end
						end else begin
							next_state = ST_WDATA;
							next_pend = state == ST_WDATA_ACK;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bitcnt == BIT_COUNT_FULL) begin
							next_oe_n = 1'b1;
							next_state = ST_RACK;
							next_acked = 1'b0;
							next_addr = addr + 8'h1;
						end else begin
							next_shreg = {shreg[6:0], 1'b1};
							next_oe_n = shreg[6];
							next_bitcnt = bitcnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						next_acked = ~sda_level;
						if (sda_level) begin
							next_state = ST_IDLE;
						end
					end else if (scl_fall && acked) begin
						next_state = ST_RDATA;
						next_shreg = mem_rd_data;
						next_oe_n = mem_rd_data[7];
						next_bitcnt = 4'h1;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
		// Memory port holds a word until the array takes it
		fifo_out_ready = !wr_en || mem_wr_ready;
		next_wr_en = wr_en;
		next_wr_word = wr_word;
		if (fifo_out_ready) begin
			next_wr_en = fifo_out_valid;
			next_wr_word = fifo_out_data;
		end
		next_prog_busy = next_state == ST_BUSY;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cmd <= CMD_MEMORY;
			shreg <= 8'h00;
			addr <= RESET_ADDR;
			bitcnt <= 4'h0;
			prot <= 4'h0;
			row <= 4'h0;
			blk <= 2'h0;
			page <= RESET_PAGE;
			pend <= 1'b0;
			acked <= 1'b0;
			oe_n <= 1'b1;
			loaded <= 1'b0;
			nv_wr <= 1'b0;
			timer <= 32'h0;
			drain <= DRAIN_DONE;
			buf_valid <= '0;
			wr_en <= 1'b0;
			wr_word <= '0;
			prog_busy <= 1'b0;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			shreg <= next_shreg;
			addr <= next_addr;
			bitcnt <= next_bitcnt;
			prot <= next_prot;
			row <= next_row;
			blk <= next_blk;
			page <= next_page;
			pend <= next_pend;
			acked <= next_acked;
			oe_n <= next_oe_n;
			loaded <= next_loaded;
			nv_wr <= next_nv_wr;
			timer <= next_timer;
			drain <= next_drain;
			buf_valid <= next_buf_valid;
			wr_en <= next_wr_en;
			wr_word <= next_wr_word;
			prog_busy <= next_prog_busy;
		end
	end

	// Row latches need no reset; valid bits guard them
	always_ff @(posedge clk) begin
		if (buf_we) begin
			buf_data[addr[3:0]] <= shreg;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	always_comb begin
		sda_out = 1'b0;
		sda_oe_n = oe_n;
		mem_rd_addr = {page, addr};
		mem_wr_en = wr_en;
		mem_wr_addr = wr_word[16:8];
		mem_wr_data = wr_word[7:0];
		prot_nv_out = prot;
		prot_nv_wr = nv_wr;
		busy = prog_busy;
	end
endmodule : spd_eeprom_serial_access

// file: hdl/spd_pkg.sv
// Constants and types of the serial presence-detect command engine.
// Assumes one 10 MHz clock; all bus timing is derived from sampled pins.
package spd_pkg;
	// ********************************
	// Clock and program cycle timing
	// ********************************
	localparam int CLK_MHZ = 10;
	localparam int PROGRAM_CYCLE_TIME_US = 5000;
	localparam int PROGRAM_CYCLE_CLKS = PROGRAM_CYCLE_TIME_US * CLK_MHZ;

	// ********************************
	// Select code fields
	// ********************************
	localparam logic [3:0] TYPE_MEMORY = 4'hA;
	localparam logic [3:0] TYPE_PROTECT = 4'h6;
	localparam logic [2:0] SEL_BLOCK0 = 3'h1;
	localparam logic [2:0] SEL_BLOCK1 = 3'h4;
	localparam logic [2:0] SEL_BLOCK2 = 3'h5;
	localparam logic [2:0] SEL_BLOCK3 = 3'h0;
	localparam logic [2:0] SEL_CLEAR_ALL = 3'h3;
	localparam logic [2:0] SEL_PAGE_LOW = 3'h6;
	localparam logic [2:0] SEL_PAGE_HIGH = 3'h7;
	localparam logic [2:0] SEL_PAGE_READ = 3'h6;

	// ********************************
	// Widths and reset values
	// ********************************
	localparam int ROW_BYTES = 16;
	localparam int WR_WORD_W = 17;
	localparam int WR_FIFO_DEPTH = 4;
	localparam logic RESET_PAGE = 1'b0;
	localparam logic [7:0] RESET_ADDR = 8'h00;
	localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
	localparam logic [4:0] DRAIN_DONE = 5'h10;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SEL = 4'h1,
		ST_SEL_ACK = 4'h3,
		ST_ADDR = 4'h2,
		ST_ADDR_ACK = 4'h6,
		ST_WDATA = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_BUSY = 4'h4,
		ST_RDATA = 4'hC,
		ST_RACK = 4'hD
	} state_t;

	typedef enum logic [1:0] {
		CMD_MEMORY = 2'h0,
		CMD_SET_BLOCK = 2'h1,
		CMD_CLEAR_ALL = 2'h2
	} cmd_t;
endpackage : spd_pkg

// file: hdl/spd_line_sampler.sv
// Two-flop synchronisers and edge detection for the bus pins and straps.
// Assumes all inputs are asynchronous to clk.
`timescale 1ns/1ps
module spd_line_sampler
	import spd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [2:0] strap_in,
	input wire logic hv_in,
	output logic scl_rise,
	output logic scl_fall,
	output logic sda_level,
	output logic start_evt,
	output logic stop_evt,
	output logic [2:0] strap_level,
	output logic hv_level
);
	// ********************************
	// Synchroniser chain
	// ********************************
	// Stage one feeds stage two only; stage three is the edge reference
	logic [5:0] stage1, stage2;
	logic [1:0] stage3;
	logic [5:0] next_stage1, next_stage2;
	logic [1:0] next_stage3;

	always_comb begin
		next_stage1 = {hv_in, strap_in, sda_in, scl_in};
		next_stage2 = stage1;
		next_stage3 = stage2[1:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 6'h03;
			stage2 <= 6'h03;
			stage3 <= 2'h3;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
			stage3 <= next_stage3;
		end
	end

	// ********************************
	// Events
	// ********************************
	always_comb begin
		scl_rise = stage2[0] & ~stage3[0];
		scl_fall = ~stage2[0] & stage3[0];
		sda_level = stage2[1];
		start_evt = stage2[0] & stage3[0] & ~stage2[1] & stage3[1];
		stop_evt = stage2[0] & stage3[0] & stage2[1] & ~stage3[1];
		strap_level = stage2[4:2];
		hv_level = stage2[5];
	end
endmodule : spd_line_sampler

// file: hdl/spd_fifo.sv
// Small valid/ready FIFO used between the write latches and the memory port.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module spd_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PW:0] count, next_count;
	logic push, pop;

	always_comb begin
		in_ready = count != (PW+1)'(DEPTH);
		out_valid = count != '0;
		out_data = store[rd_ptr];
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage carries no reset; only count decides what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end
endmodule : spd_fifo

// file: testbench/spd_serial_access_monitor.sv
// Port checker of the serial command engine.
// Assumes a bind onto spd_eeprom_serial_access; one clock domain.
`timescale 1ns/1ps
module spd_serial_access_monitor #(
	parameter int PROG_CYCLES = 200
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sda_oe_n,
	input wire logic busy,
	input wire logic mem_wr_en,
	input wire logic mem_wr_ready,
	input wire logic [8:0] mem_wr_addr,
	input wire logic [7:0] mem_wr_data,
	input wire logic [3:0] prot_nv_out,
	input wire logic prot_nv_wr
);
	// ********************************
	// Busy length counter
	// ********************************
	logic [31:0] bcnt;
	logic [31:0] next_bcnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_comb begin
		next_bcnt = busy ? bcnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt <= 32'h0;
		end else begin
			bcnt <= next_bcnt;
		end
	end
	// ********************************
	// Assertions
	// ********************************
	busy_quiet_a: assert property (busy |-> sda_oe_n)
		else $error("data line pulled while programming");
	wr_in_busy_a: assert property (mem_wr_en |-> busy)
		else $error("array write outside program cycle");
	wr_hold_a: assert property (mem_wr_en && !mem_wr_ready |=>
		mem_wr_en && $stable(mem_wr_addr) && $stable(mem_wr_data))
		else $error("array write word dropped or changed");
	nv_pulse_a: assert property (prot_nv_wr |=> !prot_nv_wr)
		else $error("store strobe longer than one cycle");
	nv_in_busy_a: assert property (prot_nv_wr |-> busy || $past(busy))
		else $error("store strobe outside program cycle");
	nv_steady_a: assert property (!busy && !$past(busy) && !prot_nv_wr && $past(rst_n)
		|=> $stable(prot_nv_out))
		else $error("protection bits moved while idle");
	busy_len_a: assert property ($fell(busy) |-> bcnt >= PROG_CYCLES)
		else $error("program cycle too short");
	busy_end_a: assert property ($rose(busy) |-> ##[1:1000] !busy)
		else $error("program cycle never ends");
	ack_len_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
		else $error("acknowledge released early");
endmodule : spd_serial_access_monitor
bind spd_eeprom_serial_access spd_serial_access_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
	.clk(clk), .rst_n(rst_n), .sda_oe_n(sda_oe_n), .busy(busy), .mem_wr_en(mem_wr_en),
	.mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
	.prot_nv_out(prot_nv_out), .prot_nv_wr(prot_nv_wr));

// file: testbench/spd_bus_master.sv
// Bus master model: makes the link clock, drives data, reads the wire.
// Assumes an 800 ns link period; the pull-up lifts a released line.
`timescale 1ns/1ps
module spd_bus_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	// ********************************
	// Bit level
	// ********************************
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Data moves only while the clock is low; idle clock stands high
	task automatic bit_io(input logic b, output logic s);
		#200 sda_m = b;
		#200 scl = 1'b1;
		#200 s = sda;
		#200 scl = 1'b0;
	endtask : bit_io
	task automatic start();
		@(negedge clk);
		#200 sda_m = 1'b1;
		#200 scl = 1'b1;
		#200 sda_m = 1'b0;
		#200 scl = 1'b0;
	endtask : start
	task automatic stop();
		#200 sda_m = 1'b0;
		#200 scl = 1'b1;
		#200 sda_m = 1'b1;
		#400;
	endtask : stop
	task automatic wb(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, ack);
	endtask : wb
	task automatic rb(input logic ma, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(ma, s);
	endtask : rb
endmodule : spd_bus_master

// file: testbench/tb_spd_eeprom_serial_access.sv
// Bench of the serial command engine with byte array and store models.
// Assumes the design package; fixed seed; link period 800 ns.
`timescale 1ns/1ps
module tb_spd_eeprom_serial_access;
	import spd_pkg::*;
	logic clk, rst_n, hv, mem_wr_ready, sda_out, sda_oe_n, mem_wr_en, prot_nv_wr, busy, pg;
	logic scl, sda_m, sda;
	logic [2:0] strap;
	logic [3:0] prot_st, prot_nv_out;
	logic [8:0] mem_rd_addr, mem_wr_addr;
	logic [7:0] mem_rd_data, mem_wr_data, sw;
	logic [7:0] mem [512];
	logic [7:0] exp [512];
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	// ********************************
	// Models and design
	// ********************************
	assign sda = sda_m & (sda_oe_n | sda_out);
	assign mem_rd_data = mem[mem_rd_addr];
	spd_bus_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	spd_eeprom_serial_access #(.PROG_CYCLES(200)) dut_u (
		.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]),
		.strap_addr_bit0(strap[0]), .high_voltage_detect(hv), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .prot_nv_in(prot_st),
		.prot_nv_out(prot_nv_out), .prot_nv_wr(prot_nv_wr), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Random stalls keep the write buffer filling up
	always @(negedge clk) begin
		mem_wr_ready <= 1'($urandom_range(1, 0));
	end
	always @(posedge clk) begin
		if (mem_wr_en && mem_wr_ready) mem[mem_wr_addr] <= mem_wr_data;
		if (prot_nv_wr) prot_st <= prot_nv_out;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ********************************
	// Tasks
	// ********************************
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	task automatic rst();
		rst_n = 1'b0;
		pg = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : rst
	task automatic wr(input logic [7:0] s, input logic [7:0] a, input int n, input logic ok);
		logic k;
		logic [7:0] v;
		m_u.start();
		m_u.wb(s, k);
		chk("wsel", k, 1'b0);
		m_u.wb(a, k);
		chk("wadr", k, 1'b0);
		for (int i = 0; i < n; i++) begin
			v = 8'($urandom());
			m_u.wb(v, k);
			chk("wdat", k, !ok);
			if (ok && s == sw) exp[{pg, a}] = v;
			a[3:0] = a[3:0] + 4'h1;
		end
		m_u.stop();
	endtask : wr
	task automatic wait_idle();
		logic k;
		int n;
		n = 0;
		k = 1'b1;
		while (k && n < 40) begin
			m_u.start();
			m_u.wb(sw, k);
			n++;
		end
		chk("poll", {n > 1, k}, 2'b10);
		m_u.stop();
	endtask : wait_idle
	task automatic rrd(input logic [7:0] a, input int n, input logic cur);
		logic k;
		logic [7:0] v;
		if (!cur) begin
			m_u.start();
			m_u.wb(sw, k);
			m_u.wb(a, k);
		end
		m_u.start();
		m_u.wb(sw | 8'h01, k);
		chk("rsel", k, 1'b0);
		for (int i = 0; i < n; i++) begin
			m_u.rb(i == n - 1, v);
			chk("rdat", v, exp[{pg, a}]);
			a++;
		end
		m_u.stop();
	endtask : rrd
	task automatic cmd(input logic [7:0] s, input logic e);
		logic k;
		m_u.start();
		m_u.wb(s, k);
		chk("cmd", k, e);
		m_u.stop();
	endtask : cmd
	// ********************************
	// Tests
	// ********************************
	initial begin
		logic k;
		void'($urandom(32'hD6AB));
		hv = 1'b0;
		mem_wr_ready = 1'b0;
		prot_st = 4'h0;
		strap = 3'($urandom_range(7, 0));
		sw = {TYPE_MEMORY, strap, 1'b0};
		for (int i = 0; i < 512; i++) begin
			mem[i] = 8'($urandom());
			exp[i] = mem[i];
		end
		rst();
		chk("idle", {busy, sda_oe_n}, 2'b01);
		$display("test reset done");
		wr(sw, 8'h1E, 3, 1'b1);
		wait_idle();
		rrd(8'h1E, 2, 1'b0);
		rrd(8'h10, 1, 1'b0);
		wr(sw, 8'h40, 16, 1'b1);
		wait_idle();
		rrd(8'h40, 16, 1'b0);
		$display("test write done");
		m_u.start();
		m_u.wb(sw, k);
		m_u.wb(8'h30, k);
		m_u.stop();
		repeat (20) @(negedge clk);
		chk("nostop", busy, 1'b0);
		rrd(8'hFF, 2, 1'b0);
		rrd(8'h01, 1, 1'b1);
		for (int i = 0; i < 2; i++) begin
			cmd(i ? (8'hB0 | (sw & 8'h0F)) : (sw ^ 8'h02), 1'b1);
		end
		$display("test read done");
		hv = 1'b1;
		wr(8'h62, 8'h00, 1, 1'b1);
		wait_idle();
		chk("setprot", prot_st, 4'h1);
		cmd(8'h63, 1'b1);
		cmd(8'h69, 1'b0);
		wr(8'h68, 8'h00, 1, 1'b1);
		wait_idle();
		chk("setprot1", prot_st, 4'h3);
		cmd(8'h69, 1'b1);
		wr(sw, 8'h10, 1, 1'b0);
		repeat (20) @(negedge clk);
		chk("noprog", busy, 1'b0);
		rrd(8'h10, 1, 1'b0);
		hv = 1'b0;
		cmd(8'h6A, 1'b1);
		$display("test protect done");
		cmd(8'h6E, 1'b0);
		pg = 1'b1;
		cmd(8'h6D, 1'b1);
		wr(sw, 8'h07, 2, 1'b1);
		wait_idle();
		rrd(8'h05, 4, 1'b0);
		rst();
		chk("nvkeep", prot_nv_out, 4'h3);
		cmd(8'h6D, 1'b0);
		hv = 1'b1;
		wr(8'h66, 8'h00, 1, 1'b1);
		wait_idle();
		chk("clear", prot_nv_out, 4'h0);
		$display("test page done");
		give_verdict();
	end
endmodule : tb_spd_eeprom_serial_access
